// >>> rtl/cfd_divider.sv
// Programmable frequency divider: period, high time and start phase
`timescale 1ns/1ps
module cfd_divider
  import cfd_pkg::*;
#(
  parameter int DIV_RATIO   = CFD_DIV_DEF,
  parameter int HIGH_CYCLES = CFD_HIGH_DEF,
  parameter int PRESET      = CFD_PRESET_DEF,
  parameter int CNT_W       = CFD_CNT_W
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Divided clock path
  input  wire logic freqIn,
  output logic      freqOut,
  output cfd_pkg::cfd_out_t status
);
  import cfd_pkg::*;

  // Clamp ratios to their documented minimum of one
  localparam int DIV_EFF  = (DIV_RATIO < 1) ? 1 : DIV_RATIO;
  localparam int HIGH_EFF = (HIGH_CYCLES < 1) ? 1 : HIGH_CYCLES;

  localparam logic signed [CNT_W-1:0] DIV_S    = CNT_W'(DIV_EFF);
  localparam logic signed [CNT_W-1:0] HIGH_S   = CNT_W'(HIGH_EFF);
  localparam logic signed [CNT_W-1:0] PRESET_S = CNT_W'(PRESET);
  localparam logic signed [CNT_W-1:0] ONE_S    = CNT_W'(1);
  // High time of a whole period or more means the output never drops
  localparam bit FULL_DUTY = (HIGH_EFF >= DIV_EFF);

  logic                    rstSync0;
  logic                    rstSync1;
  logic                    inRise;
  logic signed [CNT_W-1:0] count;
  logic signed [CNT_W-1:0] next_count;
  logic signed [CNT_W-1:0] highLeft;
  logic signed [CNT_W-1:0] next_highLeft;
  logic                    next_out;
  logic                    wrapNow;
  logic                    startHigh;
  logic                    highPending;
  logic                    keepHigh;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync0 <= 1'b0;
      rstSync1 <= 1'b0;
    end
    else
    begin
      rstSync0 <= 1'b1;
      rstSync1 <= rstSync0;
    end
  end

  cfd_sync u_sync
  (
    .clk        (clk),
    .rstN       (rstSync1),
    .asyncIn    (freqIn),
    .syncOut    (),
    .riseStrobe (inRise)
  );

  // Latency from an input rise to the output: two sync stages plus the
  // output register; inputs must hold each level one clock or more.
  // Input edges closer than that are lost, not queued.

  // A count at or below zero is still working off the preset: no wrap
  always_comb
  begin
    wrapNow = 1'b0;
    if (count >= DIV_S && count > 0)
    begin
      wrapNow = 1'b1;
    end
  end

  // Count step: one per input rising edge, nothing otherwise
  always_comb
  begin
    next_count = count;
    if (inRise)
    begin
      if (wrapNow)
      begin
        next_count = ONE_S;
      end
      else
      begin
        next_count = count + ONE_S;
      end
    end
  end

  // High phase opens on the edge that brings the count to one
  always_comb
  begin
    startHigh = 1'b0;
    if (inRise && next_count == ONE_S)
    begin
      startHigh = 1'b1;
    end
  end

  // High cycles still owed after the current one
  always_comb
  begin
    highPending = 1'b0;
    if (highLeft > 0)
    begin
      highPending = 1'b1;
    end
  end

  always_comb
  begin
    next_highLeft = highLeft;
    if (startHigh)
    begin
      next_highLeft = HIGH_S - ONE_S;
    end
    else if (inRise && highPending)
    begin
      next_highLeft = highLeft - ONE_S;
    end
  end

  // Full duty holds only once started, so a negative preset still
  // keeps the output low until the count first reaches one
  always_comb
  begin
    keepHigh = 1'b0;
    if (FULL_DUTY && freqOut)
    begin
      keepHigh = 1'b1;
    end
  end

  // Output level for the coming cycle
  always_comb
  begin
    next_out = freqOut;
    if (startHigh)
    begin
      next_out = 1'b1;
    end
    else if (inRise && !highPending && !keepHigh)
    begin
      next_out = 1'b0;
    end
  end

  // Counter starts from the preset, may be negative
  always_ff @(posedge clk or negedge rstSync1)
  begin
    if (!rstSync1)
    begin
      count <= PRESET_S;
    end
    else
    begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk or negedge rstSync1)
  begin
    if (!rstSync1)
    begin
      highLeft <= '0;
    end
    else
    begin
      highLeft <= next_highLeft;
    end
  end

  always_ff @(posedge clk or negedge rstSync1)
  begin
    if (!rstSync1)
    begin
      freqOut <= CFD_OUT_RESET;
    end
    else
    begin
      freqOut <= next_out;
    end
  end

  // Status mirrors the output; the rise flag lasts one clock
  always_ff @(posedge clk or negedge rstSync1)
  begin
    if (!rstSync1)
    begin
      status <= '0;
    end
    else
    begin
      status.divOut  <= next_out;
      status.outRise <= next_out & ~freqOut;
    end
  end

endmodule : cfd_divider

// >>> common/cfd_pkg.sv
// Constants and carrier types for the clock frequency divider
package cfd_pkg;

  localparam int CFD_CNT_W       = 16;
  localparam int CFD_DIV_DEF     = 2;
  localparam int CFD_HIGH_DEF    = 1;
  localparam int CFD_PRESET_DEF  = 0;
  localparam int CFD_SYNC_STAGES = 2;
  localparam logic CFD_OUT_RESET = 1'b0;

  typedef struct packed {
    logic divOut;
    logic outRise;
  } cfd_out_t;

endpackage : cfd_pkg

// >>> rtl/cfd_sync.sv
// Two-stage synchroniser with rising-edge detect on the stable copy
`timescale 1ns/1ps
module cfd_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstN,
  // Asynchronous level in, synchronous outputs
  input  wire logic asyncIn,
  output logic      syncOut,
  output logic      riseStrobe
);
  logic meta;
  logic prev;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      meta    <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta    <= asyncIn;
      syncOut <= meta;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      prev <= 1'b0;
    else
      prev <= syncOut;
  end

  // Falling edges produce nothing
  assign riseStrobe = syncOut & ~prev;

endmodule : cfd_sync

// >>> tb/cfd_sva.sv
// Port checker
`timescale 1ns/1ps
module cfd_sva
  import cfd_pkg::*;
(
  input logic     clk,
  input logic     nrst,
  input logic     freqIn,
  input logic     freqOut,
  input cfd_out_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_high; freqOut [*3]; endsequence
  sequence s_low; !freqOut [*3]; endsequence
  property p_chg;
    $changed(freqOut) |-> $past(freqIn, 3) && !$past(freqIn, 4);
  endproperty
  a_chg: assert property (p_chg) else $error("move");
  property p_hi; $rose(freqOut) |=> s_high; endproperty
  a_hi: assert property (p_hi) else $error("high");
  property p_lo; $fell(freqOut) |=> s_low; endproperty
  a_lo: assert property (p_lo) else $error("low");
  property p_rst;
    disable iff (1'b0) !nrst |-> !freqOut && status == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_rise; status.outRise == $rose(freqOut); endproperty
  a_rise: assert property (p_rise) else $error("rise flag");
  property p_copy; status.divOut == freqOut; endproperty
  a_copy: assert property (p_copy) else $error("copy");
endmodule : cfd_sva
bind cfd_divider cfd_sva cfd_sva_inst (.clk, .nrst, .freqIn, .freqOut,
  .status);

// >>> tb/cfd_src.sv
// Upstream clock source
`timescale 1ns/1ps
module cfd_src
(
  input  logic clk,
  input  logic en,
  output logic freqIn
);
  logic [1:0] ph = 2'h0;
  // Idles low
  always @(negedge clk) ph <= en ? ph + 2'h1 : 2'h0;
  assign freqIn = ph[1];
endmodule : cfd_src

// >>> tb/cfd_divider_test.sv
// Divider bench
`timescale 1ns/1ps
module cfd_divider_test;
  localparam int DIV = 3, HIGH = 2, PRE = -2;
  logic clk = 1'b0, nrst = 1'b0, en = 1'b0, freqIn, freqOut;
  cfd_pkg::cfd_out_t status;
  int n_errors = 0, check_count = 0, cnt;
  cfd_divider #(.DIV_RATIO(DIV), .HIGH_CYCLES(HIGH), .PRESET(PRE))
    cfd_divider_inst (.clk, .nrst, .freqIn, .freqOut, .status);
  cfd_src cfd_src_inst (.clk, .en, .freqIn);
  initial forever #2.5 clk = ~clk;
  task automatic check(input logic got, exp);
    check_count++;
    n_errors += int'(got !== exp);
    if (got !== exp) $display("unexpected %0t %b", $time, got);
  endtask : check
  task automatic tally_and_finish;
    $display("errors %0d of %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic t_div;
    en <= 1'b0;
    nrst <= 1'b0;
    cnt = PRE;
    repeat (10) @(negedge clk);
    check(freqOut, 1'b0);
    check(status.outRise, 1'b0);
    nrst <= 1'b1;
    repeat (4) @(negedge clk);
    en <= 1'b1;
    @(negedge clk);
    repeat (12)
    begin
      repeat (4) @(negedge clk);
      cnt = cnt >= DIV ? 1 : cnt + 1;
      check(freqOut, cnt >= 1 && cnt <= HIGH);
      check(status.outRise, cnt == 1);
      check(status.divOut, cnt >= 1 && cnt <= HIGH);
    end
  endtask : t_div
  initial
  begin
    t_div;
    t_div;
    tally_and_finish;
  end
  initial
  begin
    #5000 n_errors++;
    tally_and_finish;
  end
endmodule : cfd_divider_test
